// ==== hdl/mshc_defs.svh ====
// Constants for the mode/supply and hardware control register pair.
`ifndef MSHC_DEFS_SVH
`define MSHC_DEFS_SVH

// ----------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------
`define MSHC_FRAME_BITS 6'h20
`define MSHC_ADDR_DONE_CNT 6'h07
`define MSHC_FRAME_RW_BIT 7
`define MSHC_FRAME_ADDR_HI 6
`define MSHC_FRAME_DATA_HI 23
`define MSHC_FRAME_DATA_LO 8
`define MSHC_SDO_PATTERN 8'h5A
`define MSHC_SDO_STATUS 8'h00

// ----------------------------------------------------------------------
// Register addresses (word indices)
// ----------------------------------------------------------------------
`define MSHC_ADDR_MSC 7'h01
`define MSHC_ADDR_HW 7'h02

// ----------------------------------------------------------------------
// Mode and supply control fields, masks and reset values
// ----------------------------------------------------------------------
`define MSHC_MSC_MODE_HI 15
`define MSHC_MSC_MODE_LO 14
`define MSHC_MSC_OV_HI 10
`define MSHC_MSC_OV_LO 9
`define MSHC_MSC_HYS 7
`define MSHC_MSC_PEAK 5
`define MSHC_MSC_RT_HI 1
`define MSHC_MSC_RT_LO 0
`define MSHC_MSC_WMASK 16'hC6A3
`define MSHC_MSC_RESTART_KEEP 16'h00A3
`define MSHC_MSC_RST_VAL 16'h0000

// ----------------------------------------------------------------------
// Hardware control fields, masks and reset values
// ----------------------------------------------------------------------
`define MSHC_HW_TSD 12
`define MSHC_HW_VSOV 11
`define MSHC_HW_SH 10
`define MSHC_HW_RDEL 9
`define MSHC_HW_QUIET 6
`define MSHC_HW_FO 5
`define MSHC_HW_WD1 2
`define MSHC_HW_WMASK 16'h1E64
`define MSHC_HW_SOFT_KEEP 16'h0200
`define MSHC_HW_RESTART_KEEP 16'h1240
`define MSHC_HW_RST_VAL 16'h0000

// ----------------------------------------------------------------------
// Mode and overvoltage reaction codes
// ----------------------------------------------------------------------
`define MSHC_MODE_NORMAL 2'h0
`define MSHC_MODE_SLEEP 2'h1
`define MSHC_MODE_STOP 2'h2
`define MSHC_MODE_RESET 2'h3
`define MSHC_OV_NONE 2'h0
`define MSHC_OV_INT 2'h1
`define MSHC_OV_RST 2'h2
`define MSHC_OV_FAILSAFE 2'h3

// ----------------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------------
`define MSHC_CLK_PERIOD_NS 10
`define MSHC_SOFT_RST_LOW_NS 10000
`define MSHC_SOFT_RST_LOW_CYC (`MSHC_SOFT_RST_LOW_NS / `MSHC_CLK_PERIOD_NS)
`define MSHC_TSD_STREAK_LIM 5'h10

`endif

// ==== hdl/mshc_pkg.sv ====
// Types shared by the mode/supply and hardware control register block.
package mshc_pkg;

	// ------------------------------------------------------------------
	// Reset pin sequencer states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MSHC_RP_IDLE = 2'b01,
		MSHC_RP_LOW = 2'b10
	} mshc_rpin_state_type;

endpackage

// ==== hdl/mshc_regs.sv ====
// Serial-accessed mode/supply and hardware control registers with side effects.
//
// Function
// RULE1 - Mode field: normal, sleep, stop, soft reset.
// RULE2 - Soft reset pulls reset pin unless quiet.
// RULE3 - Overvoltage reaction: none, interrupt, reset, failsafe.
// RULE4 - Hysteresis bit forces highest release threshold.
// RULE5 - Peak bit picks low or high threshold.
// RULE6 - Two-bit field picks reset threshold, 00 highest.
// RULE7 - Reserved bits always read as zero.
// RULE8 - Mode register resets; restart keeps 7,5,1:0.
// RULE9 - Serial write cannot move stop to sleep.
// RULE10 - Entering restart sets mode to normal.
// RULE11 - Write answer returns previously programmed content.
// RULE12 - Thermal wait x64 after over 16 events.
// RULE13 - Battery overvoltage bit picks comparator threshold.
// RULE14 - Sample-and-hold enabled while disable bit zero.
// RULE15 - Reset delay bit: 10 ms or 2 ms.
// RULE16 - Software fail output only with fail pin configuration.
// RULE17 - Watchdog stop-off bit one deactivates in stop.
// RULE18 - Host frame bit 7 selects write.
// RULE19 - Restart clears software fail output bit.
// RULE20 - Stop-to-normal clears watchdog stop-off bit.
// RULE21 - Hardware register resets; soft reset keeps bit 9.
// RULE22 - Only writes and documented hardware updates change fields.
`include "mshc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mshc_regs #(
	parameter int SYNC_W = 4
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Serial link pins.
	input wire logic spi_sclk_i,
	input wire logic spi_csn_i,
	input wire logic spi_sdi_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	// Device state machine events, same clock.
	input wire logic restart_enter_i,
	input wire logic stop_to_normal_i,
	// Supply and thermal monitors.
	input wire logic main_supply_ov_i,
	input wire logic thermal_shutdown_level_two_event_i,
	input wire logic thermal_shutdown_level_two_streak_clr_i,
	// Failure output inputs, same clock.
	input wire logic wake_pin_fail_cfg_i,
	input wire logic fail_trigger_i,
	// Mode and supply controls.
	output logic [1:0] device_mode_o,
	output logic soft_reset_o,
	output logic reset_output_pin_n_o,
	output logic ov_interrupt_event_o,
	output logic ov_reset_event_o,
	output logic ov_failsafe_enter_o,
	output logic undervolt_release_hysteresis_sel_o,
	output logic regulator_peak_threshold_sel_o,
	output logic [1:0] undervolt_reset_threshold_sel_o,
	// Hardware option controls.
	output logic thermal_wait_x64_o,
	output logic battery_overvolt_threshold_sel_o,
	output logic gate_sample_hold_en_o,
	output logic reset_delay_short_o,
	output logic failure_output_o,
	output logic watchdog_stop_off_b1_o
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic [SYNC_W-1:0] sync3_ff;
	logic [SYNC_W-1:0] filt_ff;
	logic [SYNC_W-1:0] filt_prev_ff;

	assign pin_raw = {main_supply_ov_i, spi_sdi_i, spi_csn_i, spi_sclk_i};
	// Three stages per pin; a change is taken once stages two and three agree.
	// Select resets high in every stage, so reset release shows no false frame.
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					sync1_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
					sync2_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
					sync3_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
					filt_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
					filt_prev_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
					if (sync2_ff[gi] == sync3_ff[gi]) begin
						filt_ff[gi] <= sync3_ff[gi];
					end
					filt_prev_ff[gi] <= filt_ff[gi];
				end
			end
		end
	endgenerate
	logic sclk_rise;
	logic sclk_fall;
	logic csn_fall;
	logic csn_rise;
	logic csn_low;
	logic ov_rise;
	// Edge events of the filtered pins.
	assign sclk_rise = filt_ff[0] & ~filt_prev_ff[0];
	assign sclk_fall = ~filt_ff[0] & filt_prev_ff[0];
	assign csn_fall = ~filt_ff[1] & filt_prev_ff[1];
	assign csn_rise = filt_ff[1] & ~filt_prev_ff[1];
	assign csn_low = ~filt_ff[1];
	assign ov_rise = filt_ff[3] & ~filt_prev_ff[3];
	// ------------------------------------------------------------------
	// Serial frame receive and answer
	// ------------------------------------------------------------------
	logic [5:0] bit_cnt_ff;
	logic [31:0] rx_ff;
	logic [15:0] rdata_ff;
	logic sdo_ff;
	logic [15:0] msc_ff;
	logic [15:0] hw_ff;
	logic [6:0] early_addr;
	logic [31:0] tx_word;
	// Frames are LSB first; after seven bits the address sits in the top of rx_ff.
	assign early_addr = rx_ff[31:25];
	assign tx_word = {`MSHC_SDO_PATTERN, rdata_ff, `MSHC_SDO_STATUS};

	// Bits are sampled on the rising serial clock and counted up to one frame.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_ff <= 6'h00;
			rx_ff <= 32'h0000_0000;
		end else if (csn_fall) begin
			bit_cnt_ff <= 6'h00;
		end else if (csn_low && sclk_rise) begin
			rx_ff <= {filt_ff[2], rx_ff[31:1]};
			if (bit_cnt_ff != `MSHC_FRAME_BITS) begin
				bit_cnt_ff <= bit_cnt_ff + 6'h01;
			end
		end
	end
	// Read data is latched once the address is known, before any write lands,
	// so a write frame answers with what was programmed before it.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_ff <= 16'h0000;
		end else if (csn_low && sclk_rise && bit_cnt_ff == `MSHC_ADDR_DONE_CNT) begin
			case (early_addr) // RULE11
				`MSHC_ADDR_MSC: rdata_ff <= msc_ff;
				`MSHC_ADDR_HW: rdata_ff <= hw_ff;
				default: rdata_ff <= 16'h0000;
			endcase
		end
	end
	// Output bits change on the falling serial clock.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sdo_ff <= 1'b0;
		end else if (csn_fall) begin
			sdo_ff <= tx_word[0];
		end else if (csn_low && sclk_fall && bit_cnt_ff != `MSHC_FRAME_BITS) begin
			sdo_ff <= tx_word[bit_cnt_ff[4:0]];
		end
	end
	assign spi_sdo_o = sdo_ff;
	assign spi_sdo_oe_o = csn_low;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic frame_wr;
	logic [6:0] frame_addr;
	logic [15:0] frame_data;
	logic wr_msc;
	logic wr_hw;
	logic soft_rst_cmd;
	logic [1:0] new_mode;
	assign frame_addr = rx_ff[`MSHC_FRAME_ADDR_HI:0];
	assign frame_data = rx_ff[`MSHC_FRAME_DATA_HI:`MSHC_FRAME_DATA_LO];
	// Only a complete frame with the write bit set stores anything.
	assign frame_wr = csn_rise && bit_cnt_ff == `MSHC_FRAME_BITS
		&& rx_ff[`MSHC_FRAME_RW_BIT]; // RULE18 RULE22
	assign wr_msc = frame_wr && frame_addr == `MSHC_ADDR_MSC;
	assign wr_hw = frame_wr && frame_addr == `MSHC_ADDR_HW;
	assign new_mode = frame_data[`MSHC_MSC_MODE_HI:`MSHC_MSC_MODE_LO];
	assign soft_rst_cmd = wr_msc && new_mode == `MSHC_MODE_RESET; // RULE1

	// ------------------------------------------------------------------
	// Mode and supply control register
	// ------------------------------------------------------------------
	// Soft reset wins over everything, then restart, then the stop-to-normal
	// update, then a serial write.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			msc_ff <= `MSHC_MSC_RST_VAL; // RULE8
		end else if (soft_rst_cmd) begin
			msc_ff <= `MSHC_MSC_RST_VAL; // RULE8
		end else if (restart_enter_i) begin
			msc_ff <= msc_ff & `MSHC_MSC_RESTART_KEEP; // RULE8 RULE10
		end else if (stop_to_normal_i) begin
			msc_ff[`MSHC_MSC_MODE_HI:`MSHC_MSC_MODE_LO] <= `MSHC_MODE_NORMAL;
		end else if (wr_msc) begin
			msc_ff <= frame_data & `MSHC_MSC_WMASK; // RULE7
			if (msc_ff[`MSHC_MSC_MODE_HI:`MSHC_MSC_MODE_LO] == `MSHC_MODE_STOP
				&& new_mode == `MSHC_MODE_SLEEP) begin
				msc_ff[`MSHC_MSC_MODE_HI:`MSHC_MSC_MODE_LO] <= `MSHC_MODE_STOP; // RULE9
			end
		end
	end

	// ------------------------------------------------------------------
	// Hardware control register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hw_ff <= `MSHC_HW_RST_VAL; // RULE21
		end else if (soft_rst_cmd) begin
			hw_ff <= hw_ff & `MSHC_HW_SOFT_KEEP; // RULE21
		end else if (restart_enter_i) begin
			hw_ff <= hw_ff & `MSHC_HW_RESTART_KEEP; // RULE19
		end else if (stop_to_normal_i) begin
			hw_ff[`MSHC_HW_WD1] <= 1'b0; // RULE20
		end else if (wr_hw) begin
			hw_ff <= frame_data & `MSHC_HW_WMASK; // RULE7 RULE22
		end
	end

	// ------------------------------------------------------------------
	// Soft reset and reset pin sequencer
	// ------------------------------------------------------------------
	localparam int RST_LOW_CYC = `MSHC_SOFT_RST_LOW_CYC;
	mshc_pkg::mshc_rpin_state_type rp_state_ff;
	logic [15:0] rp_cnt_ff;
	logic soft_rst_ff;
	// The quiet bit is read before the soft reset clears it, so the host's
	// setting in force at the command decides the pin; the core pulse is one cycle.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rp_state_ff <= mshc_pkg::MSHC_RP_IDLE;
			rp_cnt_ff <= 16'h0000;
			soft_rst_ff <= 1'b0;
		end else begin
			soft_rst_ff <= soft_rst_cmd; // RULE1
			case (rp_state_ff)
				mshc_pkg::MSHC_RP_IDLE: begin
					if (soft_rst_cmd && !hw_ff[`MSHC_HW_QUIET]) begin
						rp_state_ff <= mshc_pkg::MSHC_RP_LOW; // RULE2
						rp_cnt_ff <= 16'(RST_LOW_CYC - 1);
					end
				end
				mshc_pkg::MSHC_RP_LOW: begin
					if (rp_cnt_ff == 16'h0000) begin
						rp_state_ff <= mshc_pkg::MSHC_RP_IDLE;
					end else begin
						rp_cnt_ff <= rp_cnt_ff - 16'h0001;
					end
				end
				default: rp_state_ff <= mshc_pkg::MSHC_RP_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Supply overvoltage reaction
	// ------------------------------------------------------------------
	logic ov_int_ff;
	logic ov_rst_ff;
	logic ov_fs_ff;
	// One pulse per overvoltage onset, routed by the reaction code.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ov_int_ff <= 1'b0;
			ov_rst_ff <= 1'b0;
			ov_fs_ff <= 1'b0;
		end else begin
			ov_int_ff <= ov_rise
				&& msc_ff[`MSHC_MSC_OV_HI:`MSHC_MSC_OV_LO] == `MSHC_OV_INT; // RULE3
			ov_rst_ff <= ov_rise
				&& msc_ff[`MSHC_MSC_OV_HI:`MSHC_MSC_OV_LO] == `MSHC_OV_RST; // RULE3
			ov_fs_ff <= ov_rise
				&& msc_ff[`MSHC_MSC_OV_HI:`MSHC_MSC_OV_LO] == `MSHC_OV_FAILSAFE; // RULE3
		end
	end
	// ------------------------------------------------------------------
	// Thermal shutdown streak and failure output
	// ------------------------------------------------------------------
	logic [4:0] tsd_streak_ff;
	logic tsd_x64_ff;
	logic fail_out_ff;
	// The streak saturates just past the limit so it never wraps back.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tsd_streak_ff <= 5'h00;
		end else if (thermal_shutdown_level_two_streak_clr_i) begin
			tsd_streak_ff <= 5'h00;
		end else if (thermal_shutdown_level_two_event_i && tsd_streak_ff <= `MSHC_TSD_STREAK_LIM) begin
			tsd_streak_ff <= tsd_streak_ff + 5'h01;
		end
	end
	// Extended wait and the failure output are registered levels.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tsd_x64_ff <= 1'b0;
			fail_out_ff <= 1'b0;
		end else begin
			tsd_x64_ff <= hw_ff[`MSHC_HW_TSD]
				&& tsd_streak_ff > `MSHC_TSD_STREAK_LIM; // RULE12
			fail_out_ff <= (hw_ff[`MSHC_HW_FO] && wake_pin_fail_cfg_i)
				|| fail_trigger_i; // RULE16
		end
	end
	// ------------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------------
	assign device_mode_o = msc_ff[`MSHC_MSC_MODE_HI:`MSHC_MSC_MODE_LO]; // RULE1
	assign soft_reset_o = soft_rst_ff;
	assign reset_output_pin_n_o = (rp_state_ff != mshc_pkg::MSHC_RP_LOW); // RULE2
	assign ov_interrupt_event_o = ov_int_ff;
	assign ov_reset_event_o = ov_rst_ff;
	assign ov_failsafe_enter_o = ov_fs_ff;
	assign undervolt_release_hysteresis_sel_o = msc_ff[`MSHC_MSC_HYS]; // RULE4
	assign regulator_peak_threshold_sel_o = msc_ff[`MSHC_MSC_PEAK]; // RULE5
	assign undervolt_reset_threshold_sel_o = msc_ff[`MSHC_MSC_RT_HI:`MSHC_MSC_RT_LO]; // RULE6
	assign thermal_wait_x64_o = tsd_x64_ff;
	assign battery_overvolt_threshold_sel_o = hw_ff[`MSHC_HW_VSOV]; // RULE13
	assign gate_sample_hold_en_o = ~hw_ff[`MSHC_HW_SH]; // RULE14
	assign reset_delay_short_o = hw_ff[`MSHC_HW_RDEL]; // RULE15
	assign failure_output_o = fail_out_ff;
	assign watchdog_stop_off_b1_o = hw_ff[`MSHC_HW_WD1]; // RULE17

endmodule // mshc_regs

`default_nettype wire

// ==== testbench/mshc_host_model.sv ====
// Host controller model that drives 32-bit serial frames.
`timescale 1ns/1ps
`default_nettype none

module mshc_host_model (
	// Clock.
	input wire logic sys_clk_i,
	// Serial pins.
	output logic sclk_o,
	output logic csn_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// ----
	// Frame engine
	// ----
	// Pins idle with select high and clock low.
	initial begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		sdi_o = 1'b0;
	end

	// One frame, LSB first; half periods of 8 cycles clear the pin filter.
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		@(posedge sys_clk_i);
		csn_o <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			sdi_o <= tx[i];
			repeat (8) @(posedge sys_clk_i);
			sclk_o <= 1'b1;
			rx[i] = sdo_i;
			repeat (8) @(posedge sys_clk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge sys_clk_i);
		csn_o <= 1'b1;
		sdi_o <= ~sdi_o; // A released line does not keep its last value.
		repeat (12) @(posedge sys_clk_i);
	endtask
endmodule // mshc_host_model

`default_nettype wire

// ==== testbench/mshc_regs_assertions.sv ====
// Port-level checker for the mode/supply and hardware control registers.
`include "mshc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mshc_regs_assertions (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Event and failure inputs.
	input wire logic restart_enter_i,
	input wire logic stop_to_normal_i,
	input wire logic thermal_shutdown_level_two_event_i,
	input wire logic thermal_shutdown_level_two_streak_clr_i,
	input wire logic wake_pin_fail_cfg_i,
	input wire logic fail_trigger_i,
	// Watched outputs.
	input wire logic [1:0] device_mode_o,
	input wire logic soft_reset_o,
	input wire logic reset_output_pin_n_o,
	input wire logic ov_interrupt_event_o,
	input wire logic ov_reset_event_o,
	input wire logic ov_failsafe_enter_o,
	input wire logic thermal_wait_x64_o,
	input wire logic failure_output_o,
	input wire logic watchdog_stop_off_b1_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	localparam int LOW_CYC = `MSHC_SOFT_RST_LOW_CYC;
	logic [10:0] low_cnt_ff;
	logic [4:0] ev_cnt_ff;
	logic [2:0] ov_vec;

	// ----
	// Helper logic
	// ----
	assign ov_vec = {ov_failsafe_enter_o, ov_reset_event_o, ov_interrupt_event_o};

	// Length of the present low phase of the reset pin.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_cnt_ff <= 11'h000;
		end else if (!reset_output_pin_n_o) begin
			low_cnt_ff <= low_cnt_ff + 11'h001;
		end else begin
			low_cnt_ff <= 11'h000;
		end
	end

	// Thermal events since the last clear, saturating so it cannot wrap.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ev_cnt_ff <= 5'h00;
		end else if (thermal_shutdown_level_two_streak_clr_i) begin
			ev_cnt_ff <= 5'h00;
		end else if (thermal_shutdown_level_two_event_i && ev_cnt_ff < 5'h11) begin
			ev_cnt_ff <= ev_cnt_ff + 5'h01;
		end
	end

	// ----
	// Assertions
	// ----
	sequence s_soft_done;
		device_mode_o == 2'h0 ##1 !soft_reset_o;
	endsequence
	soft_pulse_a: assert property (soft_reset_o |-> s_soft_done)
		else $error("soft reset pulse or mode clear wrong");
	mode_code_a: assert property (device_mode_o != 2'h3)
		else $error("mode field holds the reset code");
	rpin_cause_a: assert property ($fell(reset_output_pin_n_o) |->
		soft_reset_o || $past(soft_reset_o))
		else $error("reset pin fell without soft reset");
	rpin_length_a: assert property ($rose(reset_output_pin_n_o) |-> low_cnt_ff == LOW_CYC)
		else $error("reset pin low time wrong");
	ov_pulse_a: assert property (ov_vec != 3'h0 |-> $onehot(ov_vec) ##1 ov_vec == 3'h0)
		else $error("overvoltage reaction pulse wrong");
	no_stop_sleep_a: assert property ($past(device_mode_o) == 2'h2 |-> device_mode_o != 2'h1)
		else $error("stop moved to sleep");
	restart_clear_a: assert property (restart_enter_i |=> device_mode_o == 2'h0)
		else $error("restart left mode set");
	restart_fail_a: assert property (restart_enter_i |->
		##2 failure_output_o == $past(fail_trigger_i))
		else $error("restart left software fail output on");
	thermal_streak_a: assert property ($rose(thermal_wait_x64_o) |-> ev_cnt_ff > 5'h10)
		else $error("thermal extension before 17 events");
	thermal_clear_a: assert property (thermal_shutdown_level_two_streak_clr_i |-> ##2 !thermal_wait_x64_o)
		else $error("thermal extension kept after clear");
	fail_trigger_a: assert property (resetn_i && $past(resetn_i) && $past(fail_trigger_i) |->
		failure_output_o)
		else $error("failure trigger did not reach output");
	fail_idle_a: assert property (!$past(wake_pin_fail_cfg_i) && !$past(fail_trigger_i) |->
		!failure_output_o)
		else $error("failure output on without cause");
	stop_normal_a: assert property (stop_to_normal_i |=>
		!watchdog_stop_off_b1_o && device_mode_o == 2'h0)
		else $error("stop to normal kept watchdog bit");
endmodule // mshc_regs_assertions

bind mshc_regs mshc_regs_assertions u_mshc_regs_assertions (.sys_clk_i, .resetn_i,
	.restart_enter_i, .stop_to_normal_i, .thermal_shutdown_level_two_event_i, .thermal_shutdown_level_two_streak_clr_i,
	.wake_pin_fail_cfg_i, .fail_trigger_i, .device_mode_o, .soft_reset_o,
	.reset_output_pin_n_o, .ov_interrupt_event_o, .ov_reset_event_o,
	.ov_failsafe_enter_o, .thermal_wait_x64_o, .failure_output_o, .watchdog_stop_off_b1_o);

`default_nettype wire

// ==== testbench/mshc_regs_test.sv ====
// Self-checking bench for the mode/supply and hardware control registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module mshc_regs_test;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic restart_enter_i = 1'b0;
	logic stop_to_normal_i = 1'b0;
	logic main_supply_ov_i = 1'b0;
	logic thermal_shutdown_level_two_event_i = 1'b0;
	logic thermal_shutdown_level_two_streak_clr_i = 1'b0;
	logic wake_pin_fail_cfg_i = 1'b0;
	logic fail_trigger_i = 1'b0;
	wire logic spi_sclk_i, spi_csn_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o;
	wire logic soft_reset_o, reset_output_pin_n_o, ov_interrupt_event_o;
	wire logic ov_reset_event_o, ov_failsafe_enter_o, thermal_wait_x64_o;
	wire logic battery_overvolt_threshold_sel_o, gate_sample_hold_en_o;
	wire logic reset_delay_short_o, failure_output_o, watchdog_stop_off_b1_o;
	wire logic undervolt_release_hysteresis_sel_o, regulator_peak_threshold_sel_o;
	wire logic [1:0] device_mode_o, undervolt_reset_threshold_sel_o;
	int n_fail = 0;
	int tests_run = 0;
	int low_n = 0;
	logic [7:0] ov_tot;
	logic [1:0] ov_code;
	logic [15:0] m;

	// ----
	// Clock, design and host
	// ----
	always #5 sys_clk_i = ~sys_clk_i;

	mshc_regs u_mshc_regs (.sys_clk_i, .resetn_i, .spi_sclk_i, .spi_csn_i, .spi_sdi_i,
		.spi_sdo_o, .spi_sdo_oe_o, .restart_enter_i, .stop_to_normal_i, .main_supply_ov_i,
		.thermal_shutdown_level_two_event_i, .thermal_shutdown_level_two_streak_clr_i, .wake_pin_fail_cfg_i, .fail_trigger_i,
		.device_mode_o, .soft_reset_o, .reset_output_pin_n_o, .ov_interrupt_event_o,
		.ov_reset_event_o, .ov_failsafe_enter_o, .undervolt_release_hysteresis_sel_o,
		.regulator_peak_threshold_sel_o, .undervolt_reset_threshold_sel_o,
		.thermal_wait_x64_o, .battery_overvolt_threshold_sel_o, .gate_sample_hold_en_o,
		.reset_delay_short_o, .failure_output_o, .watchdog_stop_off_b1_o);

	mshc_host_model u_mshc_host_model (.sys_clk_i(sys_clk_i), .sclk_o(spi_sclk_i),
		.csn_o(spi_csn_i), .sdi_o(spi_sdi_i), .sdo_i(spi_sdo_o));

	// Event monitor: overvoltage pulses and reset pin low cycles.
	always @(posedge sys_clk_i) begin
		if (ov_interrupt_event_o === 1'b1) {ov_code, ov_tot} = {2'h1, ov_tot + 8'h01};
		if (ov_reset_event_o === 1'b1) {ov_code, ov_tot} = {2'h2, ov_tot + 8'h01};
		if (ov_failsafe_enter_o === 1'b1) {ov_code, ov_tot} = {2'h3, ov_tot + 8'h01};
		if (reset_output_pin_n_o === 1'b0) low_n++;
	end

	// ----
	// Access tasks
	// ----
	// One frame; the answer's 16-bit data field is returned and its fixed bytes checked.
	task automatic acc(input logic [6:0] a, input logic w, input logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] rx;
		u_mshc_host_model.xfer({8'hA5, d, w, a}, rx);
		q = rx[23:8];
		`CHK("answer fixed bytes", 16'h5A00, {rx[31:24], rx[7:0]})
	endtask

	// A write answers with the content from before it.
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [15:0] old);
		logic [15:0] q;
		acc(a, 1'b1, d, q);
		`CHK("write answer", old, q)
	endtask

	// A read carries an all-ones payload that must not be stored.
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] q;
		acc(a, 1'b0, 16'hFFFF, q);
		`CHK("read value", e, q)
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog sized at about three times the expected run.
	initial begin
		repeat (50000) @(posedge sys_clk_i);
		n_fail++;
		stop_test();
	end

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (4) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		`CHK("sdo enable idle", 1'b0, spi_sdo_oe_o)
		repeat (2) @(posedge sys_clk_i);
		rd(7'h01, 16'h0000);
		rd(7'h02, 16'h0000);
		`CHK("sample hold on", 1'b1, gate_sample_hold_en_o)
		wr(7'h01, 16'h3FFF, 16'h0000);
		rd(7'h01, 16'h06A3);
		`CHK("threshold bits", 4'hF, {undervolt_release_hysteresis_sel_o,
			regulator_peak_threshold_sel_o, undervolt_reset_threshold_sel_o})
		m = 16'h06A3;
		for (int c = 0; c < 4; c++) begin
			wr(7'h01, 16'h00A3 | (16'(c) << 9), m);
			m = 16'h00A3 | (16'(c) << 9);
			{ov_code, ov_tot} = 10'h000;
			main_supply_ov_i <= 1'b1;
			repeat (12) @(posedge sys_clk_i);
			`CHK("ov reaction", {2'(c), 8'(c != 0)}, {ov_code, ov_tot})
			main_supply_ov_i <= 1'b0;
			repeat (12) @(posedge sys_clk_i);
		end
		wr(7'h02, 16'hFFFF, 16'h0000);
		rd(7'h02, 16'h1E64);
		`CHK("hw options", 4'hB, {battery_overvolt_threshold_sel_o, gate_sample_hold_en_o,
			reset_delay_short_o, watchdog_stop_off_b1_o})
		wake_pin_fail_cfg_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		`CHK("sw fail output", 1'b1, failure_output_o)
		wake_pin_fail_cfg_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		`CHK("fail needs pin cfg", 1'b0, failure_output_o)
		fail_trigger_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		`CHK("failure trigger", 1'b1, failure_output_o)
		fail_trigger_i <= 1'b0;
		for (int i = 0; i < 17; i++) begin
			`CHK("thermal x1", 1'b0, thermal_wait_x64_o)
			thermal_shutdown_level_two_event_i <= 1'b1;
			@(posedge sys_clk_i);
			thermal_shutdown_level_two_event_i <= 1'b0;
			repeat (3) @(posedge sys_clk_i);
		end
		`CHK("thermal x64", 1'b1, thermal_wait_x64_o)
		thermal_shutdown_level_two_streak_clr_i <= 1'b1;
		@(posedge sys_clk_i);
		thermal_shutdown_level_two_streak_clr_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		`CHK("thermal cleared", 1'b0, thermal_wait_x64_o)
		wr(7'h01, 16'h86A3, 16'h06A3);
		wr(7'h01, 16'h46A3, 16'h86A3);
		`CHK("stop kept", 2'h2, device_mode_o)
		stop_to_normal_i <= 1'b1;
		@(posedge sys_clk_i);
		stop_to_normal_i <= 1'b0;
		rd(7'h01, 16'h06A3);
		rd(7'h02, 16'h1E60);
		wr(7'h01, 16'h46A3, 16'h06A3);
		wake_pin_fail_cfg_i <= 1'b1;
		restart_enter_i <= 1'b1;
		@(posedge sys_clk_i);
		restart_enter_i <= 1'b0;
		rd(7'h01, 16'h00A3);
		rd(7'h02, 16'h1240);
		`CHK("restart fail off", 1'b0, failure_output_o)
		wr(7'h02, 16'h0200, 16'h1240);
		low_n = 0;
		wr(7'h01, 16'hC000, 16'h00A3);
		repeat (1010) @(posedge sys_clk_i);
		`CHK("reset pin low", 1000, low_n)
		rd(7'h01, 16'h0000);
		rd(7'h02, 16'h0200);
		wr(7'h02, 16'h0240, 16'h0200);
		low_n = 0;
		wr(7'h01, 16'hC000, 16'h0000);
		repeat (20) @(posedge sys_clk_i);
		`CHK("quiet soft reset", 0, low_n)
		rd(7'h02, 16'h0200);
		wr(7'h03, 16'hFFFF, 16'h0000);
		rd(7'h03, 16'h0000);
		stop_test();
	end
endmodule // mshc_regs_test

`default_nettype wire
